// >>> pkg/serial_rx_defs.svh
// Named constants for the serial receiver: register word indexes, bit positions,
// reset values and oversampling figures. Assumes inclusion by bare name.
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH
`define IDX_STATUS 3'h0
`define IDX_CTRL_B 3'h1
`define IDX_CTRL_C 3'h2
`define IDX_DATA 3'h3
`define ST_RXC 7
`define ST_FE 4
`define ST_DOR 3
`define ST_PE 2
`define ST_U2X 1
`define CB_RXCIE 7
`define CB_RXEN 4
`define CB_SZ2 2
`define CB_RXB8 1
`define CC_PEN 5
`define CC_PODD 4
`define CC_SBS 3
`define CC_SZ1 2
`define CC_SZ0 1
`define RST_SZ 3'h3
`define SZ_5 3'h0
`define SZ_6 3'h1
`define SZ_7 3'h2
`define SZ_9 3'h7
`define LEN_5 4'h5
`define LEN_6 4'h6
`define LEN_7 4'h7
`define LEN_8 4'h8
`define LEN_9 4'h9
`define OSR_NORMAL 5'h10
`define OSR_DOUBLE 5'h08
`define VOTE_NORMAL 5'h08
`define VOTE_DOUBLE 5'h04
`define SAMPLE_FIRST 5'h01
`define BUF_FULL 2'h2
`endif

// >>> pkg/serial_rx_pkg.sv
// Types shared by the serial receiver modules.
// Assumes the defs header is not needed here; only widths appear.
package serial_rx_pkg;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_BITS = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;
    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic pe;
        logic dor;
    } rx_entry_t;
    typedef struct packed {
        rx_entry_t [1:0] mem;
        logic rd;
        logic [1:0] cnt;
    } buf_state_t;
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic u2x;
        logic rxcie;
        logic rxen;
        logic [2:0] sz;
        logic pen;
        logic podd;
        logic sbs;
        rx_state_t state;
        logic [4:0] cnt;
        logic [1:0] votes;
        logic prev;
        logic [3:0] bitn;
        logic [8:0] shreg;
        logic par;
        logic pend;
        rx_entry_t pend_entry;
        logic ovr;
    } top_state_t;
endpackage : serial_rx_pkg

// >>> pkg/rx_frame_if.sv
// Carries one received frame from the recovery logic into the receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rx_frame_if;
    logic valid;
    logic ready;
    serial_rx_pkg::rx_entry_t entry;
    modport src(output valid, output entry, input ready);
    modport dst(input valid, input entry, output ready);
endinterface : rx_frame_if
`default_nettype wire

// >>> rtl/rx_line_sync.sv
// Two-stage synchroniser for the receive pin.
// Assumes the pin idles high and is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module rx_line_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rx_o
);
    serial_rx_pkg::sync_state_t s_ff;
    serial_rx_pkg::sync_state_t nxt_s;
    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = pin_i;
        nxt_s.s2 = s_ff.s1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= 2'h3;
        end else begin
            s_ff <= nxt_s;
        end
    end
    assign rx_o = s_ff.s2;
endmodule : rx_line_sync
`default_nettype wire

// >>> rtl/rx_buffer.sv
// Two-entry receive buffer holding each character with its error flags.
// A pop requested while no entry is present is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_defs.svh"
module rx_buffer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic pop_i,
    rx_frame_if.dst wr,
    output logic head_valid_o,
    output serial_rx_pkg::rx_entry_t head_o
);
    serial_rx_pkg::buf_state_t s_ff;
    serial_rx_pkg::buf_state_t nxt_s;
    logic push;
    logic pop;
    assign wr.ready = (s_ff.cnt != `BUF_FULL);
    assign push = wr.valid & wr.ready;
    assign pop = pop_i & (s_ff.cnt != 2'h0);
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.rd ^ s_ff.cnt[0]] = wr.entry;
        end
        if (pop) begin
            nxt_s.rd = ~s_ff.rd;
        end
        nxt_s.cnt = 2'(s_ff.cnt + {1'b0, push} - {1'b0, pop});
        if (flush_i) begin
            nxt_s.rd = 1'b0;
            nxt_s.cnt = 2'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
    assign head_valid_o = (s_ff.cnt != 2'h0);
    assign head_o = s_ff.mem[s_ff.rd];
endmodule : rx_buffer
`default_nettype wire

// >>> rtl/async_serial_receiver_status.sv
// Asynchronous serial receiver with a classic Wishbone register slave.
// Assumes sample_tick_i pulses once per oversample period from the baud
// generator and global_irq_enable_i comes from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_defs.svh"
// Function
// - Receive-complete flag is one exactly while the buffer holds an unread character.
// - Clearing receiver enable flushes the buffer so receive-complete reads zero.
// - Interrupt requested while flag, its enable and global enable are all one.
// - Data read advances read position; flags then show the next character.
// - Frame, overrun and parity error flags are stored per character, read via status.
// - Status writes never change error flags; error flags raise no interrupt.
// - Frame error reads one when the first stop bit was sampled zero.
// - Two-entry buffer; overrun when full, one waiting, and new start detected.
// - Overrun flag clears when a character moves successfully into the buffer.
// - Parity check active only with parity enable; odd select picks the sense.
// - Parity error reads zero when checking is off, else stored result.
// - Line sampled at sixteen times baud, eight times in double speed.
// - Start bit voted on samples 8-10 or 4-6; high majority rejects it.
// - After rejection search resumes; synchronisation repeats for each start bit.
// - Sixteen or eight states per bit; bit value is centre three majority.
// - Only the first stop bit is evaluated; further stop bits are ignored.
// - Next start accepted right after stop vote; double speed one sample later.
// - Clearing enable abandons reception at once and releases the pin.
// - After the first stop bit the frame moves from shift register to buffer.
// - Unused upper data bits of short characters read as zero.
// - Parity bit sits between last data bit and first stop bit.
// - First voted sample is eight in normal and four in double speed.
module async_serial_receiver_status (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic sample_tick_i,
    input wire logic global_irq_enable_i,
    input wire logic serial_receive_pin_i,
    output logic rx_complete_irq_o,
    output logic rx_pin_owned_o
);
    serial_rx_pkg::top_state_t s_ff;
    serial_rx_pkg::top_state_t nxt_s;
    serial_rx_pkg::rx_entry_t head;
    logic head_valid;
    logic rx_line;
    logic pop;
    logic req;
    logic [2:0] idx;
    logic mapped;
    logic [4:0] osr;
    logic [4:0] vote_first;
    logic [4:0] vote_last;
    logic [4:0] stop_end;
    logic [4:0] cnt_step;
    logic [3:0] len;
    logic [3:0] total_bits;
    logic in_vote;
    logic at_decide;
    logic maj;
    rx_frame_if frame ();

    function automatic logic majority3(input logic a, input logic b, input logic c);
        majority3 = (a & b) | (a & c) | (b & c);
    endfunction : majority3

    function automatic logic [3:0] char_len(input logic [2:0] sz);
        if (sz == `SZ_5) begin
            char_len = `LEN_5;
        end else if (sz == `SZ_6) begin
            char_len = `LEN_6;
        end else if (sz == `SZ_7) begin
            char_len = `LEN_7;
        end else if (sz == `SZ_9) begin
            char_len = `LEN_9;
        end else begin
            char_len = `LEN_8;
        end
    endfunction : char_len

    rx_line_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(serial_receive_pin_i),
        .rx_o(rx_line)
    );

    rx_buffer u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(~s_ff.rxen),
        .pop_i(pop),
        .wr(frame.dst),
        .head_valid_o(head_valid),
        .head_o(head)
    );

    // Bus decode. The slave answers every request one cycle after it is seen.
    assign req = cyc_i & stb_i & ~s_ff.ack;
    assign idx = adr_i[4:2];
    assign mapped = (adr_i[7:5] == 3'h0);
    assign pop = req & ~we_i & mapped & (idx == `IDX_DATA);

    assign osr = s_ff.u2x ? `OSR_DOUBLE : `OSR_NORMAL;
    assign vote_first = s_ff.u2x ? `VOTE_DOUBLE : `VOTE_NORMAL;
    assign vote_last = 5'(vote_first + 5'h02);
    assign stop_end = s_ff.u2x ? 5'(vote_last + 5'h01) : vote_last;
    assign cnt_step = (s_ff.cnt == osr) ? `SAMPLE_FIRST : 5'(s_ff.cnt + 5'h01);
    assign len = char_len(s_ff.sz);
    assign total_bits = 4'(len + {3'h0, s_ff.pen});
    assign in_vote = (s_ff.cnt >= vote_first) && (s_ff.cnt < vote_last);
    assign at_decide = (s_ff.cnt == vote_last);
    assign maj = majority3(s_ff.votes[1], s_ff.votes[0], rx_line);

    assign frame.valid = s_ff.pend;
    assign frame.entry = '{
        data: s_ff.pend_entry.data,
        fe: s_ff.pend_entry.fe,
        pe: s_ff.pend_entry.pe,
        dor: s_ff.ovr
    };

    always_comb begin
        nxt_s = s_ff;
        nxt_s.ack = req;
        nxt_s.irq = head_valid & s_ff.rxcie & global_irq_enable_i;

        // Register reads; unmapped addresses read zero and are still acknowledged.
        if (req & ~we_i) begin
            nxt_s.dat = 32'h0000_0000;
            if (!mapped) begin
                nxt_s.dat = 32'h0000_0000;
            end else if (idx == `IDX_STATUS) begin
                nxt_s.dat[`ST_RXC] = head_valid;
                nxt_s.dat[`ST_FE] = head_valid & head.fe;
                nxt_s.dat[`ST_DOR] = head_valid & head.dor;
                nxt_s.dat[`ST_PE] = head_valid & head.pe & s_ff.pen;
                nxt_s.dat[`ST_U2X] = s_ff.u2x;
            end else if (idx == `IDX_CTRL_B) begin
                nxt_s.dat[`CB_RXCIE] = s_ff.rxcie;
                nxt_s.dat[`CB_RXEN] = s_ff.rxen;
                nxt_s.dat[`CB_SZ2] = s_ff.sz[2];
                nxt_s.dat[`CB_RXB8] = head_valid & head.data[8];
            end else if (idx == `IDX_CTRL_C) begin
                nxt_s.dat[`CC_PEN] = s_ff.pen;
                nxt_s.dat[`CC_PODD] = s_ff.podd;
                nxt_s.dat[`CC_SBS] = s_ff.sbs;
                nxt_s.dat[`CC_SZ1] = s_ff.sz[1];
                nxt_s.dat[`CC_SZ0] = s_ff.sz[0];
            end else if (idx == `IDX_DATA) begin
                nxt_s.dat[7:0] = head_valid ? head.data[7:0] : 8'h00;
            end
        end

        // Register writes; only byte lane zero holds bits.
        if (req & we_i & sel_i[0] & mapped) begin
            if (idx == `IDX_STATUS) begin
                nxt_s.u2x = dat_i[`ST_U2X];
            end else if (idx == `IDX_CTRL_B) begin
                nxt_s.rxcie = dat_i[`CB_RXCIE];
                nxt_s.rxen = dat_i[`CB_RXEN];
                nxt_s.sz[2] = dat_i[`CB_SZ2];
            end else if (idx == `IDX_CTRL_C) begin
                nxt_s.pen = dat_i[`CC_PEN];
                nxt_s.podd = dat_i[`CC_PODD];
                nxt_s.sbs = dat_i[`CC_SBS];
                nxt_s.sz[1] = dat_i[`CC_SZ1];
                nxt_s.sz[0] = dat_i[`CC_SZ0];
            end
        end

        if (frame.valid & frame.ready) begin
            nxt_s.pend = 1'b0;
            nxt_s.ovr = 1'b0;
        end

        if (sample_tick_i) begin
            if (s_ff.state != serial_rx_pkg::RX_IDLE) begin
                nxt_s.cnt = cnt_step;
                if (in_vote) begin
                    nxt_s.votes = {s_ff.votes[0], rx_line};
                end
            end
            case (s_ff.state)
                serial_rx_pkg::RX_IDLE: begin
                    nxt_s.prev = rx_line;
                    if (s_ff.prev && !rx_line) begin
                        nxt_s.state = serial_rx_pkg::RX_START;
                        nxt_s.cnt = `SAMPLE_FIRST;
                    end
                end
                serial_rx_pkg::RX_START: begin
                    if (at_decide) begin
                        if (maj) begin
                            nxt_s.state = serial_rx_pkg::RX_IDLE;
                            nxt_s.prev = rx_line;
                        end else begin
                            nxt_s.state = serial_rx_pkg::RX_BITS;
                            nxt_s.bitn = 4'h0;
                            nxt_s.shreg = 9'h000;
                            nxt_s.par = 1'b0;
                            if (nxt_s.pend) begin
                                nxt_s.pend = 1'b0;
                                nxt_s.ovr = 1'b1;
                            end
                        end
                    end
                end
                serial_rx_pkg::RX_BITS: begin
                    if (at_decide) begin
                        if (s_ff.bitn < len) begin
                            nxt_s.shreg[s_ff.bitn] = maj;
                        end else begin
                            nxt_s.par = maj;
                        end
                        nxt_s.bitn = 4'(s_ff.bitn + 4'h1);
                        if (4'(s_ff.bitn + 4'h1) == total_bits) begin
                            nxt_s.state = serial_rx_pkg::RX_STOP;
                        end
                    end
                end
                serial_rx_pkg::RX_STOP: begin
                    if (at_decide) begin
                        nxt_s.pend = 1'b1;
                        nxt_s.pend_entry.data = s_ff.shreg;
                        nxt_s.pend_entry.fe = ~maj;
                        nxt_s.pend_entry.pe = s_ff.pen & (^s_ff.shreg ^ s_ff.par ^ s_ff.podd);
                        nxt_s.pend_entry.dor = 1'b0;
                        nxt_s.bitn = 4'(s_ff.bitn + 4'h1);
                    end
                    // Early next start. Double speed enters here at the exit
                    // sample, so the bit count tells whether the stop vote was taken.
                    if ((s_ff.cnt == stop_end) && (at_decide || (s_ff.bitn != total_bits))) begin
                        nxt_s.state = serial_rx_pkg::RX_IDLE;
                        nxt_s.prev = rx_line;
                    end
                end
                default: begin
                    nxt_s.state = serial_rx_pkg::RX_IDLE;
                end
            endcase
        end

        if (!s_ff.rxen) begin
            nxt_s.state = serial_rx_pkg::RX_IDLE;
            nxt_s.cnt = `SAMPLE_FIRST;
            nxt_s.prev = 1'b1;
            nxt_s.pend = 1'b0;
            nxt_s.ovr = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '{
                ack: 1'b0,
                dat: 32'h0000_0000,
                irq: 1'b0,
                u2x: 1'b0,
                rxcie: 1'b0,
                rxen: 1'b0,
                sz: `RST_SZ,
                pen: 1'b0,
                podd: 1'b0,
                sbs: 1'b0,
                state: serial_rx_pkg::RX_IDLE,
                cnt: `SAMPLE_FIRST,
                votes: 2'h0,
                prev: 1'b1,
                bitn: 4'h0,
                shreg: 9'h000,
                par: 1'b0,
                pend: 1'b0,
                pend_entry: '0,
                ovr: 1'b0
            };
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dat_o = s_ff.dat;
    assign ack_o = s_ff.ack;
    assign rx_complete_irq_o = s_ff.irq;
    assign rx_pin_owned_o = s_ff.rxen;
endmodule : async_serial_receiver_status
`default_nettype wire

// >>> tb/serial_rx_asserts.sv
// Concurrent checks on the serial receiver top-level ports.
// Assumes a single clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic sample_tick_i,
    input wire logic global_irq_enable_i,
    input wire logic serial_receive_pin_i,
    input wire logic rx_complete_irq_o,
    input wire logic rx_pin_owned_o
);
    // Shadows lag the design by one cycle, so checks on them allow that slack.
    logic pen_ff;
    logic rxcie_ff;
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign rd_ok = cyc_i & stb_i & ~we_i & ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pen_ff <= 1'b0;
            rxcie_ff <= 1'b0;
        end else begin
            if (wr_ok && adr_i == 8'h08) begin
                pen_ff <= dat_i[5];
            end
            if (wr_ok && adr_i == 8'h04) begin
                rxcie_ff <= dat_i[7];
            end
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    upper_zero_a: assert property (rd_ok |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    unmapped_zero_a: assert property (rd_ok && adr_i[7:5] != 3'h0 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    empty_flags_a: assert property (rd_ok && adr_i == 8'h00 && !dat_o[7] |-> dat_o[4:2] == 3'h0)
        else $error("error flags set with empty buffer");
    parity_mask_a: assert property (rd_ok && adr_i == 8'h00 && !pen_ff |-> !dat_o[2])
        else $error("parity error shown with checking off");
    irq_global_a: assert property (!global_irq_enable_i |=> !rx_complete_irq_o)
        else $error("interrupt with global enable low");
    irq_enable_a: assert property (!rxcie_ff && !$past(rxcie_ff) |-> !rx_complete_irq_o)
        else $error("interrupt with its enable low");
    pin_release_a: assert property (wr_ok && adr_i == 8'h04 |-> rx_pin_owned_o == dat_i[4])
        else $error("pin ownership does not follow enable");
    flush_irq_a: assert property (!rx_pin_owned_o [*3] |-> !rx_complete_irq_o)
        else $error("interrupt while receiver disabled");
    irq_seen_c: cover property (rx_complete_irq_o);
    status_full_c: cover property (rd_ok && adr_i == 8'h00 && dat_o[7]);
    disable_c: cover property (wr_ok && adr_i == 8'h04 && !dat_i[4]);
endmodule : serial_rx_asserts
bind async_serial_receiver_status serial_rx_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .sample_tick_i(sample_tick_i),
    .global_irq_enable_i(global_irq_enable_i), .serial_receive_pin_i(serial_receive_pin_i),
    .rx_complete_irq_o(rx_complete_irq_o), .rx_pin_owned_o(rx_pin_owned_o));
`default_nettype wire

// >>> tb/serial_tx_model.sv
// Remote asynchronous transmitter driving the receive line.
// Assumes tick_i is the receiver's oversample pulse, so bit length is osr ticks.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
    input wire logic clk_i,
    input wire logic tick_i,
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic bitv(input logic v, input int osr);
        line_o <= v;
        repeat (osr) begin
            do begin
                @(posedge clk_i);
            end while (tick_i !== 1'b1);
        end
    endtask : bitv
    // Low-going pulse that ends before the start vote samples are taken.
    task automatic glitch(input int n);
        bitv(1'b0, n);
        bitv(1'b1, 32);
    endtask : glitch
    task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic podd,
                        input logic bad, input logic stop, input int osr);
        logic p;
        int i;
        p = ^(d & ((9'h001 << nb) - 9'h001)) ^ podd ^ bad;
        bitv(1'b0, osr);
        for (i = 0; i < nb; i++) begin
            bitv(d[i], osr);
        end
        if (pen) begin
            bitv(p, osr);
        end
        bitv(stop, osr);
        // A broken stop needs an idle bit so the next start has a falling edge.
        if (!stop) begin
            bitv(1'b1, osr);
        end
    endtask : send
endmodule : serial_tx_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the serial receiver with a Wishbone master.
// Assumes the oversample tick pulses every second clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic tick = 1'b0;
    logic gie = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq;
    logic own;
    logic line;
    int mismatches = 0;
    int samples_checked = 0;
    async_serial_receiver_status dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .dat_o(dat_o), .ack_o(ack_o), .sample_tick_i(tick), .global_irq_enable_i(gie),
        .serial_receive_pin_i(line), .rx_complete_irq_o(irq), .rx_pin_owned_o(own));
    serial_tx_model tx (.clk_i(clk_i), .tick_i(tick), .line_o(line));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tick <= ~tick;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Holds the request until ack is sampled high at a rising edge, then releases it.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rc
    task automatic wait_rxc;
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0, q);
            n++;
        end while (q[7] !== 1'b1 && n < 40);
        if (n >= 40) chk("rx complete", 32'h80, q);
    endtask : wait_rxc
    task automatic t_reset;
        rc(8'h00, 32'h0, "status");
        rc(8'h04, 32'h0, "control b");
        rc(8'h08, 32'h06, "control c");
        rc(8'h20, 32'h0, "unmapped");
        chk("pin owned", 32'h0, {31'h0, own});
        $display("test reset done");
    endtask : t_reset
    task automatic t_basic;
        wr(8'h04, 32'h10);
        tx.send(9'h0A5, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h00, 32'h80, "status");
        rc(8'h0C, 32'hA5, "data");
        rc(8'h00, 32'h00, "status");
        tx.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b0, 16);
        wait_rxc;
        rc(8'h00, 32'h90, "status");
        // Error positions are written as zero; only double speed may change.
        wr(8'h00, 32'h00);
        rc(8'h00, 32'h90, "status");
        rc(8'h0C, 32'h3C, "data");
        $display("test basic done");
    endtask : t_basic
    task automatic t_parity;
        int m;
        for (m = 0; m < 2; m++) begin
            wr(8'h08, 32'h26 | (m << 4));
            tx.send(9'h0B4, 8, 1'b1, m[0], 1'b0, 1'b1, 16);
            tx.send(9'h07E, 8, 1'b1, m[0], 1'b1, 1'b1, 16);
            wait_rxc;
            rc(8'h00, 32'h80, "status");
            rc(8'h0C, 32'hB4, "data");
            rc(8'h00, 32'h84, "status");
            wr(8'h08, 32'h06);
            rc(8'h00, 32'h80, "status");
            rc(8'h0C, 32'h7E, "data");
        end
        $display("test parity done");
    endtask : t_parity
    task automatic t_overrun;
        tx.send(9'h011, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        tx.send(9'h022, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        tx.send(9'h033, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        tx.send(9'h044, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h0C, 32'h11, "data");
        rc(8'h00, 32'h80, "status");
        rc(8'h0C, 32'h22, "data");
        rc(8'h00, 32'h88, "status");
        rc(8'h0C, 32'h44, "data");
        tx.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h00, 32'h80, "status");
        rc(8'h0C, 32'h55, "data");
        $display("test overrun done");
    endtask : t_overrun
    task automatic t_modes;
        tx.glitch(4);
        tx.send(9'h05A, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h0C, 32'h5A, "data");
        rc(8'h00, 32'h00, "status");
        wr(8'h00, 32'h02);
        tx.glitch(2);
        tx.send(9'h0C3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 8);
        wait_rxc;
        rc(8'h0C, 32'hC3, "data");
        rc(8'h00, 32'h02, "status");
        wr(8'h00, 32'h00);
        wr(8'h04, 32'h14);
        tx.send(9'h1C3, 9, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h04, 32'h16, "ninth bit");
        rc(8'h0C, 32'hC3, "data");
        wr(8'h04, 32'h10);
        wr(8'h08, 32'h00);
        tx.send(9'h1FF, 5, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        rc(8'h0C, 32'h1F, "data");
        wr(8'h08, 32'h0E);
        rc(8'h08, 32'h0E, "control c");
        $display("test modes done");
    endtask : t_modes
    task automatic t_irq_disable;
        wr(8'h04, 32'h90);
        gie <= 1'b1;
        tx.send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
        wait_rxc;
        chk("irq", 32'h1, {31'h0, irq});
        gie <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h04, 32'h00);
        repeat (3) @(posedge clk_i);
        chk("pin owned", 32'h0, {31'h0, own});
        rc(8'h00, 32'h00, "status");
        wr(8'h04, 32'h10);
        rc(8'h00, 32'h00, "status");
        fork
            tx.send(9'h0FF, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
            begin
                repeat (120) @(posedge clk_i);
                wr(8'h04, 32'h00);
                wr(8'h04, 32'h10);
            end
        join
        repeat (40) @(posedge clk_i);
        rc(8'h00, 32'h00, "status");
        $display("test irq and disable done");
    endtask : t_irq_disable
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_basic;
        t_parity;
        t_overrun;
        t_modes;
        t_irq_disable;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
